// *** logic/alarm_defines.svh ***
// Register offsets, field positions and reset values for the alarm pin setup logic.
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH
`define ADDR_W 8
`define ADDR_SETUP 8'h06
`define ADDR_STAT_A 8'h43
`define ADDR_STAT_B 8'h44
`define ADDR_CLEAR 8'h45
`define ADDR_IRQ_MASK 8'h46
`define SETUP_RESET 16'h0000
`define BIT_OT_LATCH 15
`define BIT_OT_DIS 14
`define BIT_SK_LATCH 13
`define BIT_SK_DIS 12
`define BIT_DG_LATCH 11
`define BIT_DG_DIS 10
`define BIT_CL_LATCH 9
`define BIT_CL_DIS 8
`define BIT_GD_LATCH 7
`define BIT_GD_DIS 6
`define SETUP_USED_MASK 16'hFFC0
`define SRC_OT 0
`define SRC_CL 1
`define SRC_GD 2
`define SRC_DG 3
`define SRC_SK 4
`define NSRC 5
`define ZERO5 5'h00
`define ZERO16 16'h0000
`endif

// *** logic/alarm_pkg.sv ***
// Types shared by the alarm pin setup logic.
package alarm_pkg;
    typedef logic [15:0] word_t;
    typedef logic [4:0] src_t;
endpackage : alarm_pkg

// *** logic/alarm_pin_setup_logic.sv ***
// Alarm pin setup register, alarm latching, open-drain alarm pins and interrupt.
// Functional notes
// - Software masks each alarm source on its own through the setup register at offset 0x6.
// - A masked source no longer pulls its open-drain pin.
// - Both alarm status registers at 0x43 and 0x44 record alarms whether masked or not.
// - Bit 15 high makes the over-temperature pin latched, low leaves it unlatched.
// - Bit 14 high disables the over-temperature pin, low keeps it enabled.
// - Bit 13 high latches the sense Kelvin alarm on the shared Kelvin pin.
// - Bit 12 high stops the sense Kelvin alarm from driving the shared Kelvin pin.
// - Bit 11 high latches the device-ground alarm on the shared Kelvin pin.
// - Bit 10 high stops the device-ground alarm from driving the shared Kelvin pin.
// - Setting the device-ground disable bit also switches off the ground sense pull-up.
// - Bit 9 high makes the clamp pin latched, low leaves it unlatched.
// - Bit 8 high disables the clamp pin, low keeps it enabled.
// - Bit 7 high latches the guard alarm on the shared Kelvin pin.
// - Bit 6 high stops the guard alarm from driving the shared Kelvin pin.
// - Guard, device-ground and sense Kelvin alarms, each gated, share one open-drain Kelvin pin.
`timescale 1ns/10ps
`include "alarm_defines.svh"
module alarm_pin_setup_logic (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire alarm_pkg::word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output alarm_pkg::word_t rdata_o,
    input wire logic overtemp_cond_i,
    input wire logic clamp_cond_i,
    input wire logic guard_cond_i,
    input wire logic device_ground_cond_i,
    input wire logic sense_kelvin_cond_i,
    output logic overtemp_alarm_out_o,
    output logic overtemp_alarm_out_oe_o,
    output logic clamp_alarm_out_o,
    output logic clamp_alarm_out_oe_o,
    output logic shared_kelvin_alarm_out_o,
    output logic shared_kelvin_alarm_out_oe_o,
    output logic device_ground_sense_in_pullup_en_o,
    output logic irq_o
);
    import alarm_pkg::*;

    word_t setup_ff;
    src_t held_ff;
    src_t irq_stat_ff;
    src_t irq_mask_ff;
    word_t rdata_ff;
    logic od_ot_ff;
    logic od_cl_ff;
    logic od_kel_ff;
    logic pull_ff;

    // Software-visible register decode.
    wire wr_setup = wr_i && (addr_i == `ADDR_SETUP);
    wire wr_clear = wr_i && (addr_i == `ADDR_CLEAR);
    wire wr_mask = wr_i && (addr_i == `ADDR_IRQ_MASK);
    wire rd_stat_a = rd_i && (addr_i == `ADDR_STAT_A);

    // Live conditions in source order.
    wire src_t live = {sense_kelvin_cond_i, device_ground_cond_i, guard_cond_i, clamp_cond_i, overtemp_cond_i};

    // Per-source latch and disable selections.
    wire src_t latch_en = {setup_ff[`BIT_SK_LATCH], setup_ff[`BIT_DG_LATCH], setup_ff[`BIT_GD_LATCH],
                           setup_ff[`BIT_CL_LATCH], setup_ff[`BIT_OT_LATCH]};
    wire src_t dis = {setup_ff[`BIT_SK_DIS], setup_ff[`BIT_DG_DIS], setup_ff[`BIT_GD_DIS],
                      setup_ff[`BIT_CL_DIS], setup_ff[`BIT_OT_DIS]};

    // Held alarms remember a condition until the clear register is written; a new event wins over the clear.
    wire src_t clr_bits = wr_clear ? wdata_i[`NSRC-1:0] : `ZERO5;
    wire src_t nxt_held = (held_ff & ~clr_bits) | live;

    // Pin level per source: the live condition, plus the held copy when latched, so both modes answer in one cycle.
    wire src_t flag = live | (latch_en & held_ff);
    wire src_t pin_req = flag & ~dis;

    wire nxt_od_ot = pin_req[`SRC_OT];
    wire nxt_od_cl = pin_req[`SRC_CL];
    wire nxt_od_kel = pin_req[`SRC_GD] | pin_req[`SRC_DG] | pin_req[`SRC_SK];
    wire nxt_pull = ~setup_ff[`BIT_DG_DIS];

    // Interrupt status is sticky and cleared by reading it; a set in the same cycle survives.
    wire src_t nxt_irq_stat = (rd_stat_a ? `ZERO5 : irq_stat_ff) | live;

    // Read mux; unmapped addresses read zero.
    wire word_t nxt_rdata = (addr_i == `ADDR_SETUP) ? setup_ff :
                            (addr_i == `ADDR_STAT_A) ? {11'h000, irq_stat_ff} :
                            (addr_i == `ADDR_STAT_B) ? {11'h000, held_ff} :
                            (addr_i == `ADDR_IRQ_MASK) ? {11'h000, irq_mask_ff} : `ZERO16;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            setup_ff <= `SETUP_RESET;
        end else if (wr_setup) begin
            // Unused low bits are not stored, so they read as zero whatever the host writes.
            setup_ff <= wdata_i & `SETUP_USED_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            held_ff <= `ZERO5;
            irq_stat_ff <= `ZERO5;
            irq_mask_ff <= `ZERO5;
            rdata_ff <= `ZERO16;
        end else begin
            held_ff <= nxt_held;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= wr_mask ? wdata_i[`NSRC-1:0] : irq_mask_ff;
            rdata_ff <= rd_i ? nxt_rdata : `ZERO16;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            od_ot_ff <= 1'b0;
            od_cl_ff <= 1'b0;
            od_kel_ff <= 1'b0;
            pull_ff <= 1'b1;
        end else begin
            od_ot_ff <= nxt_od_ot;
            od_cl_ff <= nxt_od_cl;
            od_kel_ff <= nxt_od_kel;
            pull_ff <= nxt_pull;
        end
    end

    // Open-drain pins only ever drive low; the enable says when.
    assign overtemp_alarm_out_o = 1'b0;
    assign clamp_alarm_out_o = 1'b0;
    assign shared_kelvin_alarm_out_o = 1'b0;
    assign overtemp_alarm_out_oe_o = od_ot_ff;
    assign clamp_alarm_out_oe_o = od_cl_ff;
    assign shared_kelvin_alarm_out_oe_o = od_kel_ff;
    assign device_ground_sense_in_pullup_en_o = pull_ff;
    assign rdata_o = rdata_ff;
    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    sequence s_ot_cond_seen;
        overtemp_cond_i && setup_ff[`BIT_OT_LATCH] && !setup_ff[`BIT_OT_DIS] && !wr_clear && !wr_setup;
    endsequence

    chk_ot_disabled_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_OT_DIS] && !wr_setup |=> !overtemp_alarm_out_oe_o)
        else $error("Disabled over-temperature pin still driven.");
    chk_ot_unlatched_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !setup_ff[`BIT_OT_LATCH] && !setup_ff[`BIT_OT_DIS] && !wr_setup |=> overtemp_alarm_out_oe_o == $past(overtemp_cond_i))
        else $error("Unlatched over-temperature pin does not follow condition.");
    chk_ot_latch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_ot_cond_seen ##1 (!wr_clear && !wr_setup) |=> overtemp_alarm_out_oe_o)
        else $error("Latched over-temperature pin dropped without clear.");
    chk_cl_disabled_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_CL_DIS] && !wr_setup |=> !clamp_alarm_out_oe_o)
        else $error("Disabled clamp pin still driven.");
    chk_cl_unlatched_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !setup_ff[`BIT_CL_LATCH] && !setup_ff[`BIT_CL_DIS] && !wr_setup |=> clamp_alarm_out_oe_o == $past(clamp_cond_i))
        else $error("Unlatched clamp pin does not follow condition.");
    chk_kel_all_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_SK_DIS] && setup_ff[`BIT_DG_DIS] && setup_ff[`BIT_GD_DIS] && !wr_setup
        |=> !shared_kelvin_alarm_out_oe_o)
        else $error("Kelvin pin driven with all sources disabled.");
    chk_kel_guard_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
        guard_cond_i && !setup_ff[`BIT_GD_DIS] && !wr_setup |=> shared_kelvin_alarm_out_oe_o)
        else $error("Guard alarm failed to pull the Kelvin pin.");
    chk_kel_sense_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sense_kelvin_cond_i && !setup_ff[`BIT_SK_DIS] && !wr_setup |=> shared_kelvin_alarm_out_oe_o)
        else $error("Sense Kelvin alarm failed to pull the Kelvin pin.");
    chk_dg_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
        device_ground_cond_i && !setup_ff[`BIT_DG_DIS] && !wr_setup |=> shared_kelvin_alarm_out_oe_o)
        else $error("Device-ground alarm failed to pull the Kelvin pin.");
    chk_pullup_follows: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 device_ground_sense_in_pullup_en_o == !$past(setup_ff[`BIT_DG_DIS]))
        else $error("Ground sense pull-up does not track disable bit.");
    chk_status_masked: assert property (@(posedge clk_i) disable iff (!nrst_i)
        overtemp_cond_i |=> held_ff[`SRC_OT] && irq_stat_ff[`SRC_OT])
        else $error("Masked alarm missing from status.");
    chk_setup_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_setup |=> setup_ff == ($past(wdata_i) & `SETUP_USED_MASK))
        else $error("Setup register write not stored.");

    // The shared Kelvin pin is an OR, so each of its sources is checked with the other two disabled.
    sequence s_cl_cond_seen;
        clamp_cond_i && setup_ff[`BIT_CL_LATCH] && !setup_ff[`BIT_CL_DIS] && !wr_clear && !wr_setup;
    endsequence

    sequence s_gd_cond_seen;
        guard_cond_i && setup_ff[`BIT_GD_LATCH] && !setup_ff[`BIT_GD_DIS] && !wr_clear && !wr_setup;
    endsequence

    sequence s_dg_cond_seen;
        device_ground_cond_i && setup_ff[`BIT_DG_LATCH] && !setup_ff[`BIT_DG_DIS] && !wr_clear && !wr_setup;
    endsequence

    sequence s_sk_cond_seen;
        sense_kelvin_cond_i && setup_ff[`BIT_SK_LATCH] && !setup_ff[`BIT_SK_DIS] && !wr_clear && !wr_setup;
    endsequence

    sequence s_ot_clear_seen;
        wr_clear && wdata_i[`SRC_OT] && !overtemp_cond_i && setup_ff[`BIT_OT_LATCH] && !wr_setup;
    endsequence

    sequence s_cl_clear_seen;
        wr_clear && wdata_i[`SRC_CL] && !clamp_cond_i && setup_ff[`BIT_CL_LATCH] && !wr_setup;
    endsequence

    chk_cl_latch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_cl_cond_seen ##1 (!wr_clear && !wr_setup)
        |=> clamp_alarm_out_oe_o)
        else $error("Latched clamp pin dropped without clear.");

    chk_gd_latch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_gd_cond_seen ##1 (!wr_clear && !wr_setup)
        |=> shared_kelvin_alarm_out_oe_o)
        else $error("Latched guard alarm dropped without clear.");

    chk_dg_latch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_dg_cond_seen ##1 (!wr_clear && !wr_setup)
        |=> shared_kelvin_alarm_out_oe_o)
        else $error("Latched device-ground alarm dropped without clear.");

    chk_sk_latch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_sk_cond_seen ##1 (!wr_clear && !wr_setup)
        |=> shared_kelvin_alarm_out_oe_o)
        else $error("Latched sense Kelvin alarm dropped without clear.");

    chk_ot_clear_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_ot_clear_seen ##1 (!overtemp_cond_i && !wr_setup)
        |=> !overtemp_alarm_out_oe_o)
        else $error("Over-temperature pin still driven after clear.");

    chk_cl_clear_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_cl_clear_seen ##1 (!clamp_cond_i && !wr_setup)
        |=> !clamp_alarm_out_oe_o)
        else $error("Clamp pin still driven after clear.");

    chk_gd_only_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !setup_ff[`BIT_GD_LATCH] && !setup_ff[`BIT_GD_DIS] && !wr_setup
        && setup_ff[`BIT_DG_DIS] && setup_ff[`BIT_SK_DIS]
        |=> shared_kelvin_alarm_out_oe_o == $past(guard_cond_i))
        else $error("Kelvin pin does not follow guard alarm.");

    chk_dg_only_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !setup_ff[`BIT_DG_LATCH] && !setup_ff[`BIT_DG_DIS] && !wr_setup
        && setup_ff[`BIT_GD_DIS] && setup_ff[`BIT_SK_DIS]
        |=> shared_kelvin_alarm_out_oe_o == $past(device_ground_cond_i))
        else $error("Kelvin pin does not follow device-ground alarm.");

    chk_sk_only_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !setup_ff[`BIT_SK_LATCH] && !setup_ff[`BIT_SK_DIS] && !wr_setup
        && setup_ff[`BIT_GD_DIS] && setup_ff[`BIT_DG_DIS]
        |=> shared_kelvin_alarm_out_oe_o == $past(sense_kelvin_cond_i))
        else $error("Kelvin pin does not follow sense Kelvin alarm.");

    chk_ot_latched_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_OT_LATCH] && !setup_ff[`BIT_OT_DIS] && overtemp_cond_i && !wr_setup
        |=> overtemp_alarm_out_oe_o)
        else $error("Latched over-temperature pin slow to assert.");

    chk_cl_latched_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_CL_LATCH] && !setup_ff[`BIT_CL_DIS] && clamp_cond_i && !wr_setup
        |=> clamp_alarm_out_oe_o)
        else $error("Latched clamp pin slow to assert.");

    chk_ot_disabled_status: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_OT_DIS] && overtemp_cond_i && !wr_setup
        |=> held_ff[`SRC_OT] && !overtemp_alarm_out_oe_o)
        else $error("Disabled over-temperature alarm lost from status.");

    chk_cl_disabled_status: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_CL_DIS] && clamp_cond_i && !wr_setup
        |=> held_ff[`SRC_CL] && !clamp_alarm_out_oe_o)
        else $error("Disabled clamp alarm lost from status.");

    chk_dg_disabled_status: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_DG_DIS] && device_ground_cond_i
        |=> held_ff[`SRC_DG] && irq_stat_ff[`SRC_DG])
        else $error("Disabled device-ground alarm lost from status.");

    chk_cl_status_seen: assert property (@(posedge clk_i) disable iff (!nrst_i)
        clamp_cond_i
        |=> held_ff[`SRC_CL] && irq_stat_ff[`SRC_CL])
        else $error("Clamp alarm missing from status.");

    chk_gd_status_seen: assert property (@(posedge clk_i) disable iff (!nrst_i)
        guard_cond_i
        |=> held_ff[`SRC_GD] && irq_stat_ff[`SRC_GD])
        else $error("Guard alarm missing from status.");

    chk_dg_status_seen: assert property (@(posedge clk_i) disable iff (!nrst_i)
        device_ground_cond_i
        |=> held_ff[`SRC_DG] && irq_stat_ff[`SRC_DG])
        else $error("Device-ground alarm missing from status.");

    chk_sk_status_seen: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sense_kelvin_cond_i
        |=> held_ff[`SRC_SK] && irq_stat_ff[`SRC_SK])
        else $error("Sense Kelvin alarm missing from status.");

    chk_held_clear_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_clear
        |=> (held_ff & $past(clr_bits) & ~$past(live)) == `ZERO5)
        else $error("Held alarm survived its clear.");

    chk_held_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !wr_clear
        |=> (held_ff & $past(held_ff)) == $past(held_ff))
        else $error("Held alarm dropped without clear.");

    chk_stat_read_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_stat_a
        |=> irq_stat_ff == $past(live))
        else $error("Interrupt status not cleared by read.");

    chk_stat_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !rd_stat_a
        |=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
        else $error("Interrupt status dropped without read.");

    chk_irq_event: assert property (@(posedge clk_i) disable iff (!nrst_i)
        overtemp_cond_i && irq_mask_ff[`SRC_OT] && !wr_mask
        |=> irq_o)
        else $error("Unmasked alarm raised no interrupt.");

    chk_mask_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_mask
        |=> irq_mask_ff == $past(wdata_i[`NSRC-1:0]))
        else $error("Interrupt mask write not stored.");

    chk_mask_stable: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !wr_mask
        |=> $stable(irq_mask_ff))
        else $error("Interrupt mask changed without write.");

    chk_setup_stable: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !wr_setup
        |=> $stable(setup_ff))
        else $error("Setup register changed without write.");

    chk_setup_low_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (setup_ff & ~`SETUP_USED_MASK) == `ZERO16)
        else $error("Unused setup bits hold a one.");

    chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !rd_i
        |=> rdata_o == `ZERO16)
        else $error("Read data not zero outside a read.");

    chk_rdata_setup: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && addr_i == `ADDR_SETUP
        |=> rdata_o == $past(setup_ff))
        else $error("Setup read returned wrong data.");

    chk_rdata_stat_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && addr_i == `ADDR_STAT_A
        |=> rdata_o[`NSRC-1:0] == $past(irq_stat_ff))
        else $error("Status A read returned wrong data.");

    chk_rdata_stat_b: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && addr_i == `ADDR_STAT_B
        |=> rdata_o[`NSRC-1:0] == $past(held_ff))
        else $error("Status B read returned wrong data.");

    chk_rdata_mask: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_i && addr_i == `ADDR_IRQ_MASK
        |=> rdata_o[`NSRC-1:0] == $past(irq_mask_ff))
        else $error("Mask read returned wrong data.");

    chk_pins_drive_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !(overtemp_alarm_out_o || clamp_alarm_out_o || shared_kelvin_alarm_out_o))
        else $error("Open-drain pin data not low.");

    chk_pullup_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
        setup_ff[`BIT_DG_DIS] && !wr_setup
        |=> !device_ground_sense_in_pullup_en_o)
        else $error("Ground sense pull-up on while disabled.");

endmodule : alarm_pin_setup_logic

// *** test/alarm_pin_monitor.sv ***
// Tester-side model of the three open-drain alarm pins and their pull-ups.
`timescale 1ns/10ps
module alarm_pin_monitor (
    input wire logic [2:0] drv_i,
    input wire logic [2:0] oe_i,
    output logic [2:0] level_o
);
    // A released pin rises to its pull-up, so it reads low only while the device pulls it.
    assign level_o = (oe_i & drv_i) | ~oe_i;
endmodule : alarm_pin_monitor

// *** test/alarm_pin_setup_logic_tb.sv ***
// Self-checking testbench for the alarm pin setup logic.
`timescale 1ns/10ps
`include "alarm_defines.svh"
module alarm_pin_setup_logic_tb;
    import alarm_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [`ADDR_W-1:0] addr_i = 8'h00;
    word_t wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    src_t cond = 5'h00;
    word_t rdata_o;
    logic [2:0] drv, oe, level;
    logic pullup_en, irq;
    int fails = 0;
    int n_checks = 0;
    int pin_of [5] = '{0, 1, 2, 2, 2};
    int dis_of [5] = '{14, 8, 6, 10, 12};
    int lat_of [5] = '{15, 9, 7, 11, 13};
    word_t s;
    always #5 clk_i = ~clk_i;
    alarm_pin_setup_logic alarm_pin_setup_logic_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .overtemp_cond_i(cond[0]),
        .clamp_cond_i(cond[1]), .guard_cond_i(cond[2]), .device_ground_cond_i(cond[3]),
        .sense_kelvin_cond_i(cond[4]), .overtemp_alarm_out_o(drv[0]), .overtemp_alarm_out_oe_o(oe[0]),
        .clamp_alarm_out_o(drv[1]), .clamp_alarm_out_oe_o(oe[1]), .shared_kelvin_alarm_out_o(drv[2]),
        .shared_kelvin_alarm_out_oe_o(oe[2]), .device_ground_sense_in_pullup_en_o(pullup_en), .irq_o(irq));
    alarm_pin_monitor alarm_pin_monitor_i (.drv_i(drv), .oe_i(oe), .level_o(level));
    task automatic chk(input string name, input word_t exp, input word_t got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input word_t v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input word_t exp, input string name);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(name, exp, rdata_o);
    endtask : rd_chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        fails++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(`ADDR_SETUP, `SETUP_RESET, "setup reset");
        chk("pullup reset", 16'h0001, {15'h0, pullup_en});
        rd_chk(8'h10, `ZERO16, "unmapped");
        // Each source runs plain, then disabled, then latched, so the dis_of and lat_of tables cover bits 15 to 6.
        for (int i = 0; i < 5; i++) begin
            for (int m = 0; m < 3; m++) begin
                s = (m == 0) ? `ZERO16 : word_t'(1 << ((m == 1) ? dis_of[i] : lat_of[i]));
                wr(`ADDR_SETUP, s);
                rd_chk(`ADDR_SETUP, s, "setup");
                chk("pullup", {15'h0, ~s[10]}, {15'h0, pullup_en});
                @(posedge clk_i);
                cond <= src_t'(1 << i);
                step(1);
                chk("pins on", (m == 1) ? `ZERO16 : word_t'(1 << pin_of[i]), {13'h0, ~level});
                @(posedge clk_i);
                cond <= `ZERO5;
                step(1);
                chk("pins off", (m == 2) ? word_t'(1 << pin_of[i]) : `ZERO16, {13'h0, ~level});
                rd_chk(`ADDR_STAT_A, word_t'(1 << i), "status a");
                chk("irq masked", `ZERO16, {15'h0, irq});
                if (m == 2) begin
                    wr(`ADDR_CLEAR, 16'h001F);
                    step(3);
                    chk("pins cleared", `ZERO16, {13'h0, ~level});
                    rd_chk(`ADDR_STAT_B, `ZERO16, "status b");
                end
            end
        end
        wr(`ADDR_IRQ_MASK, 16'h0001);
        @(posedge clk_i);
        cond <= 5'h02;
        step(3);
        chk("irq other", `ZERO16, {15'h0, irq});
        @(posedge clk_i);
        cond <= 5'h01;
        step(3);
        chk("irq set", 16'h0001, {15'h0, irq});
        @(posedge clk_i);
        cond <= `ZERO5;
        rd_chk(`ADDR_STAT_A, 16'h0003, "status a both");
        step(2);
        chk("irq clear", `ZERO16, {15'h0, irq});
        complete_run;
    end
endmodule : alarm_pin_setup_logic_tb
